// ### bscc_top.sv
// boundary-scan test port with configuration interplay, oversampling the test clock
`timescale 1ns/10ps
module bscc_top
  import bscc_pkg::*;
#(
  parameter int BSR_LEN = BSR_LEN_DEFAULT,
  parameter logic [ID_W-1:0] ID_VALUE = ID_DEFAULT // arbitrary identity value
) (
  input wire logic sys_clk_in,
  input wire logic rst_b_in,
  input wire logic tck_in,
  input wire logic tms_in,
  input wire logic tdi_in,
  input wire logic config_restart_n_in,
  input wire logic chip_wide_clear_n_in,
  input wire logic chip_wide_output_enable_in,
  input wire logic config_done_in,
  input wire logic always_en_inbuf_in,
  input wire logic [ID_W-1:0] usercode_in,
  input wire logic [BSR_LEN-1:0] pin_level_in,
  input wire logic [BSR_LEN-1:0] keeper_en_in,
  output logic tdo_out,
  output logic tdo_oe_n_out,
  output logic config_abort_out,
  output logic config_pulse_out,
  output logic pin_float_out,
  output logic pin_scan_drive_out,
  output logic [BSR_LEN-1:0] bsr_update_out,
  output logic [BSR_LEN-1:0] keeper_hold_out,
  output logic inbuf_out_only_en_out
);
  // chip_wide_clear_n_in and chip_wide_output_enable_in are deliberately unread,
  // so neither can disturb scan or configuration through the port [R9]

  localparam int SW = 4 + BSR_LEN; // tck, tms, tdi, restart pin, pins

  // synchronised outside inputs
  logic [SW-1:0] sync_w;
  logic tck_s, tms_s, tdi_s, restart_n_s;
  logic [BSR_LEN-1:0] pin_level_s;

  bscc_sync #(.W(SW)) u_sync (
    .sys_clk_in(sys_clk_in),
    .rst_b_in(rst_b_in),
    // restart pin enters inverted so the cleared synchroniser reads as released
    .async_in({pin_level_in, ~config_restart_n_in, tdi_in, tms_in, tck_in}),
    .sync_out(sync_w)
  );

  assign tck_s = sync_w[0];
  assign tms_s = sync_w[1];
  assign tdi_s = sync_w[2];
  assign restart_n_s = ~sync_w[3]; // back to pin polarity, idle high straight after reset
  assign pin_level_s = sync_w[SW-1:4];

  // registers
  logic tck_prev_q; // last sampled test clock, for edge finding
  logic restart_prev_q; // last sampled restart pin
  bscc_tap_t state_q; // controller state
  logic [IR_W-1:0] ir_shift_q; // instruction shift stage
  logic [IR_W-1:0] ir_q; // loaded instruction
  logic bypass_q; // single bypass stage
  logic [ID_W-1:0] id_shift_q; // identity / user code shift stage
  logic [BSR_LEN-1:0] bsr_shift_q; // boundary shift stage
  logic [BSR_LEN-1:0] bsr_update_q; // boundary update stage
  logic io_mode_q; // configuration interrupted, port owns the buffers
  logic tdo_q, tdo_oe_n_q;
  logic pulse_q, float_q, drive_q, inbuf_q;
  logic [BSR_LEN-1:0] keeper_q;

  // next controller state for a given tms level
  function automatic bscc_tap_t tap_next(input bscc_tap_t st, input logic tms);
    bscc_tap_t nx;
    nx = st;
    unique case (st)
      TAP_RESET: nx = tms ? TAP_RESET : TAP_IDLE;
      TAP_IDLE: nx = tms ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_DR: nx = tms ? TAP_SEL_IR : TAP_CAP_DR;
      TAP_CAP_DR: nx = tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
      TAP_SHIFT_DR: nx = tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
      TAP_EXIT1_DR: nx = tms ? TAP_UPD_DR : TAP_PAUSE_DR;
      TAP_PAUSE_DR: nx = tms ? TAP_EXIT2_DR : TAP_PAUSE_DR;
      TAP_EXIT2_DR: nx = tms ? TAP_UPD_DR : TAP_SHIFT_DR;
      TAP_UPD_DR: nx = tms ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_IR: nx = tms ? TAP_RESET : TAP_CAP_IR;
      TAP_CAP_IR: nx = tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
      TAP_SHIFT_IR: nx = tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
      TAP_EXIT1_IR: nx = tms ? TAP_UPD_IR : TAP_PAUSE_IR;
      TAP_PAUSE_IR: nx = tms ? TAP_EXIT2_IR : TAP_PAUSE_IR;
      TAP_EXIT2_IR: nx = tms ? TAP_UPD_IR : TAP_SHIFT_IR;
      TAP_UPD_IR: nx = tms ? TAP_SEL_DR : TAP_IDLE;
    endcase
    return nx;
  endfunction : tap_next

  // codes that may run while configuration is still loading
  function automatic logic cfg_safe(input logic [IR_W-1:0] code);
    return (code == IR_BYPASS) || (code == IR_IDCODE) || (code == IR_SAMPLE) || (code == IR_CONFIG_IO); // [R5]
  endfunction : cfg_safe

  // edge strobes of the sampled test clock and restart pin
  wire tck_rise = tck_s & ~tck_prev_q;
  wire tck_fall = ~tck_s & tck_prev_q;
  wire restart_rise = restart_n_s & ~restart_prev_q;

  // the port owns pins once configured or once configuration is interrupted
  wire pins_allowed = config_done_in | io_mode_q;
  // an unsafe code during configuration acts as bypass and leaves pins alone
  wire [IR_W-1:0] eff_ir = (pins_allowed || cfg_safe(ir_q)) ? ir_q : IR_BYPASS; // [R5] [R18]

  // data register selection; unknown and all-ones codes fall to bypass
  wire sel_id = (eff_ir == IR_IDCODE) || (eff_ir == IR_USERCODE);
  wire sel_bsr = (eff_ir == IR_SAMPLE) || (eff_ir == IR_EXTEST);
  wire sel_bypass = ~sel_id & ~sel_bsr; // [R2] [R16]

  // instruction-update strobes, evaluated on the code being loaded
  wire upd_ir = tck_rise && (state_q == TAP_UPD_IR);
  wire load_cfg_io = upd_ir && (ir_shift_q == IR_CONFIG_IO);
  wire load_pulse = upd_ir && (ir_shift_q == IR_PULSE_CONFIG) && pins_allowed;

  // serial bit for tdo, chosen by which shift state is current
  wire dr_bit = sel_id ? id_shift_q[0] : (sel_bsr ? bsr_shift_q[0] : bypass_q);
  wire ser_bit = (state_q == TAP_SHIFT_IR) ? ir_shift_q[0] : dr_bit;
  wire in_shift = (state_q == TAP_SHIFT_IR) || (state_q == TAP_SHIFT_DR);

  // pin control decode
  wire float_w = (eff_ir == IR_HIGHZ); // [R1]
  wire clamp_w = (eff_ir == IR_CLAMP);
  wire drive_w = (eff_ir == IR_EXTEST) || clamp_w;
  // keepers win over float or clamp only on a configured part
  wire [BSR_LEN-1:0] keeper_w = {BSR_LEN{(float_w | clamp_w) & config_done_in}} & keeper_en_in; // [R3]
  // output-only input buffers: on when unconfigured, by option, or under sample
  wire inbuf_w = ~config_done_in | always_en_inbuf_in | (eff_ir == IR_SAMPLE); // [R10] [R11]

  // edge history; reset leaves the controller in test-logic reset, always live
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      tck_prev_q <= 1'b0;
      restart_prev_q <= 1'b1; // idle level of the pin, so reset release is no false release
      state_q <= TAP_RESET; // [R4]
    end else begin
      tck_prev_q <= tck_s;
      restart_prev_q <= restart_n_s;
      if (tck_rise) begin
        state_q <= tap_next(state_q, tms_s);
      end
    end
  end

  // instruction path: capture pattern, shift on rise, load on update
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ir_shift_q <= IR_CAPTURE;
      ir_q <= IR_IDCODE;
    end else if (tck_rise) begin
      if (state_q == TAP_CAP_IR) begin
        ir_shift_q <= IR_CAPTURE; // [R12]
      end else if (state_q == TAP_SHIFT_IR) begin
        ir_shift_q <= {tdi_s, ir_shift_q[IR_W-1:1]}; // [R15] [R17]
      end
      if (state_q == TAP_RESET) begin
        ir_q <= IR_IDCODE;
      end else if (state_q == TAP_UPD_IR) begin
        ir_q <= ir_shift_q; // float state holds until another code lands [R1]
      end
    end
  end

  // data path: capture, shift from tdi on rise, boundary update
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      bypass_q <= 1'b0;
      id_shift_q <= '0;
      bsr_shift_q <= '0;
      bsr_update_q <= '0;
    end else if (tck_rise) begin
      if (state_q == TAP_CAP_DR) begin
        bypass_q <= 1'b0;
        id_shift_q <= (eff_ir == IR_USERCODE) ? usercode_in : ID_VALUE;
        bsr_shift_q <= pin_level_s;
      end else if (state_q == TAP_SHIFT_DR) begin
        if (sel_bypass) begin
          bypass_q <= tdi_s; // [R2] [R15] [R16]
        end
        if (sel_id) begin
          id_shift_q <= {tdi_s, id_shift_q[ID_W-1:1]};
        end
        if (sel_bsr) begin
          bsr_shift_q <= {tdi_s, bsr_shift_q[BSR_LEN-1:1]};
        end
      end else if ((state_q == TAP_UPD_DR) && sel_bsr) begin
        bsr_update_q <= bsr_shift_q;
      end
    end
  end

  // tdo and its enable change only on falling edges
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      tdo_q <= 1'b0;
      tdo_oe_n_q <= 1'b1;
    end else if (tck_fall) begin
      tdo_q <= ser_bit; // [R12] [R15]
      tdo_oe_n_q <= ~in_shift; // [R14]
    end
  end

  // configuration interrupt and restart; pin restart takes effect at its release,
  // so a restart pin held low through pre-config testing does not end the interrupt
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      io_mode_q <= 1'b0;
      pulse_q <= 1'b0;
    end else begin
      pulse_q <= load_pulse; // [R7]
      if (load_cfg_io) begin
        io_mode_q <= 1'b1; // [R6]
      end else if (load_pulse || restart_rise) begin
        io_mode_q <= 1'b0; // [R7] [R8]
      end
    end
  end

  // pin control outputs, registered every system cycle
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      float_q <= 1'b0;
      drive_q <= 1'b0;
      keeper_q <= '0;
      inbuf_q <= 1'b1;
    end else begin
      float_q <= float_w; // [R1]
      drive_q <= drive_w; // [R18]
      keeper_q <= keeper_w; // [R3]
      inbuf_q <= inbuf_w; // [R10] [R11]
    end
  end

  assign tdo_out = tdo_q;
  assign tdo_oe_n_out = tdo_oe_n_q;
  assign config_abort_out = io_mode_q;
  assign config_pulse_out = pulse_q;
  assign pin_float_out = float_q;
  assign pin_scan_drive_out = drive_q;
  assign bsr_update_out = bsr_update_q;
  assign keeper_hold_out = keeper_q;
  assign inbuf_out_only_en_out = inbuf_q;
endmodule : bscc_top

// ### bscc_pkg.sv
// constants, codes and state type for the boundary-scan and configuration control block
// What this block does
// [R1] float-all instruction tri-states every user pin
// [R2] float-all instruction routes bypass stage serially
// [R3] configured keeper or pull-up overrides float
// [R4] scan logic active from reset, no enable
// [R5] only bypass, id, sample and io-configure run during configuration
// [R6] io-configure instruction aborts configuration in progress
// [R7] tester restarts configuration after interrupted testing
// [R8] tester holds restart pin low during pre-config tests
// [R9] chip-wide clear and enable ignored
// [R10] output-only input buffers off once configured; sample enables them
// [R11] always-enable option keeps all input buffers on
// [R12] instruction capture shifts out 1010101010 first
// [R13] tester reaches instruction shift with 01100
// [R14] tdo driven only in shift states, falling edge
// [R15] tdi taken on rise, tdo on fall
// [R16] all-ones instruction selects the bypass stage
// [R17] instruction register is ten bits wide
// [R18] unsafe instruction during configuration leaves pins alone
package bscc_pkg;
  // instruction register width and capture pattern (bit 0 leaves first)
  localparam int IR_W = 10;
  localparam logic [IR_W-1:0] IR_CAPTURE = 10'h155;
  // instruction codes; only all-ones is fixed, the rest are local picks
  localparam logic [IR_W-1:0] IR_BYPASS = 10'h3FF;
  localparam logic [IR_W-1:0] IR_SAMPLE = 10'h005;
  localparam logic [IR_W-1:0] IR_EXTEST = 10'h00F;
  localparam logic [IR_W-1:0] IR_IDCODE = 10'h006;
  localparam logic [IR_W-1:0] IR_USERCODE = 10'h007;
  localparam logic [IR_W-1:0] IR_CLAMP = 10'h00A;
  localparam logic [IR_W-1:0] IR_HIGHZ = 10'h00B;
  localparam logic [IR_W-1:0] IR_CONFIG_IO = 10'h00D;
  localparam logic [IR_W-1:0] IR_PULSE_CONFIG = 10'h001;
  // identification register width and default value (value is arbitrary)
  localparam int ID_W = 32;
  localparam logic [ID_W-1:0] ID_DEFAULT = 32'h0000_1235;
  // default boundary register length, one cell per user pin
  localparam int BSR_LEN_DEFAULT = 16;
  // synchroniser depth for the test clock, mode, data, restart pin and pin level inputs
  localparam int SYNC_STAGES = 2;

  // test access port controller states
  typedef enum logic [3:0] {
    TAP_RESET = 4'h0,
    TAP_IDLE = 4'h1,
    TAP_SEL_DR = 4'h2,
    TAP_CAP_DR = 4'h3,
    TAP_SHIFT_DR = 4'h4,
    TAP_EXIT1_DR = 4'h5,
    TAP_PAUSE_DR = 4'h6,
    TAP_EXIT2_DR = 4'h7,
    TAP_UPD_DR = 4'h8,
    TAP_SEL_IR = 4'h9,
    TAP_CAP_IR = 4'hA,
    TAP_SHIFT_IR = 4'hB,
    TAP_EXIT1_IR = 4'hC,
    TAP_PAUSE_IR = 4'hD,
    TAP_EXIT2_IR = 4'hE,
    TAP_UPD_IR = 4'hF
  } bscc_tap_t;
endpackage : bscc_pkg

// ### bscc_sync.sv
// two-stage synchroniser bank for inputs from outside the system clock domain
`timescale 1ns/10ps
module bscc_sync #(
  parameter int W = 1
) (
  input wire logic sys_clk_in,
  input wire logic rst_b_in,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] meta_q; // first stage, read only by the second stage
  logic [W-1:0] sync_q; // second stage, safe for logic

  // plain double flop; no filtering, the caller does edge work on sync_q
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;
endmodule : bscc_sync

// ### bscc_assertions.sv
// concurrent checks on the ports of the scan and configuration control block
`timescale 1ns/10ps
module bscc_assertions
  import bscc_pkg::*;
#(
  parameter int BSR_LEN = BSR_LEN_DEFAULT
) (
  input wire logic sys_clk_in,
  input wire logic rst_b_in,
  input wire logic tck_in,
  input wire logic config_restart_n_in,
  input wire logic config_done_in,
  input wire logic always_en_inbuf_in,
  input wire logic [BSR_LEN-1:0] keeper_en_in,
  input wire logic tdo_out,
  input wire logic tdo_oe_n_out,
  input wire logic config_abort_out,
  input wire logic config_pulse_out,
  input wire logic pin_float_out,
  input wire logic pin_scan_drive_out,
  input wire logic [BSR_LEN-1:0] keeper_hold_out,
  input wire logic inbuf_out_only_en_out
);
  // one domain, so clock and reset are given once
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rst_b_in);
  // tdo enable moves only once the test clock pin has been low a while
  oe_at_fall_a: assert property ($changed(tdo_oe_n_out) |-> !tck_in && !$past(tck_in, 2))
    else $error("tdo enable moved outside a test clock fall");
  tdo_at_fall_a: assert property ($changed(tdo_out) |-> !tck_in && !$past(tck_in, 2))
    else $error("tdo moved outside a test clock fall");
  float_not_drive_a: assert property (pin_float_out |-> !pin_scan_drive_out)
    else $error("pins floated and driven at once");
  keeper_override_a: assert property (pin_float_out |->
    keeper_hold_out == ($past(config_done_in) ? $past(keeper_en_in) : '0))
    else $error("keeper hold does not follow keeper enables");
  inbuf_on_a: assert property ($past(!config_done_in || always_en_inbuf_in) |-> inbuf_out_only_en_out)
    else $error("input buffers off while they must be on");
  // abort is only set from a test clock rise, never by the chip-wide pins
  abort_from_tck_a: assert property ($rose(config_abort_out) |-> tck_in && $past(tck_in, 3))
    else $error("abort set without a test clock rise");
  abort_clear_a: assert property ($fell(config_abort_out) |->
    config_pulse_out || (config_restart_n_in && $past(config_restart_n_in, 3)))
    else $error("abort cleared without restart");
  pulse_single_a: assert property (config_pulse_out |=> !config_pulse_out)
    else $error("restart pulse longer than one cycle");
  pulse_clears_a: assert property (config_pulse_out |-> !config_abort_out)
    else $error("abort still set during restart pulse");
  // main scenarios reached
  cover property ($rose(config_abort_out));
  cover property (config_pulse_out);
  cover property (pin_float_out && (|keeper_hold_out));
endmodule : bscc_assertions

bind bscc_top bscc_assertions #(.BSR_LEN(BSR_LEN)) u_chk (.sys_clk_in, .rst_b_in, .tck_in, .config_restart_n_in,
  .config_done_in, .always_en_inbuf_in, .keeper_en_in, .tdo_out, .tdo_oe_n_out, .config_abort_out,
  .config_pulse_out, .pin_float_out, .pin_scan_drive_out, .keeper_hold_out, .inbuf_out_only_en_out);

// ### bscc_tester.sv
// boundary-scan tester model: drives test clock, mode and data lines
`timescale 1ns/10ps
module bscc_tester (
  input wire logic tdo_line_in,
  output logic tck_out,
  output logic tms_out,
  output logic tdi_out
);
  // test clock stands low between transfers; mode high keeps the port in reset
  initial begin
    tck_out = 1'b0;
    tms_out = 1'b1;
    tdi_out = 1'b0;
  end
  // one 125 ns period; tdo taken just before the rise, as a real tester does
  task automatic step(input logic m, input logic d, output logic o);
    tms_out = m;
    tdi_out = d;
    #62.5;
    o = tdo_line_in;
    tck_out = 1'b1;
    #62.5;
    tck_out = 1'b0;
  endtask : step
  // walk to a shift state, move n bits lsb first, update, park in idle
  task automatic scan(input logic ir, input int n, input logic [31:0] d, output logic [31:0] q);
    logic o;
    q = '0;
    step(1'b0, 1'b0, o);
    step(1'b1, 1'b0, o);
    if (ir) step(1'b1, 1'b0, o);
    step(1'b0, 1'b0, o);
    step(1'b0, 1'b0, o);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, d[i], o);
      q[i] = o;
    end
    step(1'b1, 1'b0, o);
    step(1'b0, 1'b0, o);
  endtask : scan
endmodule : bscc_tester

// ### testbench.sv
// self-checking bench for the scan and configuration control block
`timescale 1ns/10ps
module testbench;
  import bscc_pkg::*;
  logic sys_clk_in = 1'b0, rst_b_in = 1'b0, config_restart_n_in = 1'b1, chip_wide_clear_n_in = 1'b1;
  logic chip_wide_output_enable_in = 1'b0, config_done_in = 1'b0, always_en_inbuf_in = 1'b0, alt = 1'b0;
  logic tck_in, tms_in, tdi_in, tdo_line, tdo_out, tdo_oe_n_out, config_abort_out, config_pulse_out;
  logic pin_float_out, pin_scan_drive_out, inbuf_out_only_en_out;
  logic [ID_W-1:0] usercode_in = '0;
  logic [BSR_LEN_DEFAULT-1:0] pin_level_in = '0, keeper_en_in = '0, bsr_update_out, keeper_hold_out;
  logic [31:0] lfsr = 32'h0000C1E5, rq;
  int fail_count = 0, comparisons = 0, cycles = 0, pulses = 0, m_pulses = 0, m_abort = 0;
  logic [IR_W-1:0] codes [11] = '{IR_HIGHZ, IR_EXTEST, IR_CLAMP, IR_USERCODE, 10'h2AA, IR_SAMPLE,
    IR_BYPASS, IR_IDCODE, IR_CONFIG_IO, IR_HIGHZ, IR_PULSE_CONFIG};
  bscc_top DUT (.sys_clk_in, .rst_b_in, .tck_in, .tms_in, .tdi_in, .config_restart_n_in, .chip_wide_clear_n_in,
    .chip_wide_output_enable_in, .config_done_in, .always_en_inbuf_in, .usercode_in, .pin_level_in,
    .keeper_en_in, .tdo_out, .tdo_oe_n_out, .config_abort_out, .config_pulse_out, .pin_float_out,
    .pin_scan_drive_out, .bsr_update_out, .keeper_hold_out, .inbuf_out_only_en_out);
  bscc_tester tester (.tdo_line_in(tdo_line), .tck_out(tck_in), .tms_out(tms_in), .tdi_out(tdi_in));
  // a released tdo toggles every cycle so a stale bit never looks valid
  assign tdo_line = tdo_oe_n_out ? alt : tdo_out;
  initial forever #2 sys_clk_in = ~sys_clk_in;
  // cycle count, restart pulse count and hang limit
  always @(posedge sys_clk_in) begin
    alt <= ~alt;
    cycles <= cycles + 1;
    if (config_pulse_out === 1'b1) pulses <= pulses + 1;
    if (cycles == 90000) begin
      fail_count++;
      conclude();
    end
  end
  function logic [31:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction : rnd
  task chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // load one code, update the model, check pins and the selected data path
  task automatic load(input logic [IR_W-1:0] c);
    logic [31:0] d;
    logic [IR_W-1:0] e;
    e = (c == IR_BYPASS || c == IR_IDCODE || c == IR_SAMPLE || c == IR_CONFIG_IO || config_done_in
      || m_abort != 0) ? c : IR_BYPASS;
    d = rnd();
    @(posedge sys_clk_in);
    #1 {chip_wide_clear_n_in, chip_wide_output_enable_in} = d[1:0];
    tester.scan(1'b1, IR_W, {22'h0, c}, rq);
    chk(rq, {22'h0, IR_CAPTURE});
    if (c == IR_CONFIG_IO) m_abort = 1;
    if (c == IR_PULSE_CONFIG && (config_done_in || m_abort != 0)) begin
      m_abort = 0;
      m_pulses++;
    end
    repeat (2) @(posedge sys_clk_in);
    #1;
    chk(pin_float_out, e == IR_HIGHZ);
    chk(pin_scan_drive_out, e == IR_EXTEST || e == IR_CLAMP);
    chk(config_abort_out, m_abort != 0);
    chk(keeper_hold_out, (config_done_in && (e == IR_HIGHZ || e == IR_CLAMP)) ? keeper_en_in : '0);
    chk(inbuf_out_only_en_out, !config_done_in || always_en_inbuf_in || e == IR_SAMPLE);
    chk(tdo_oe_n_out, 1'b1);
    d = rnd();
    if (e == IR_IDCODE || e == IR_USERCODE) begin
      tester.scan(1'b0, ID_W, d, rq);
      chk(rq, e == IR_IDCODE ? ID_DEFAULT : usercode_in);
    end else if (e == IR_SAMPLE || e == IR_EXTEST) begin
      tester.scan(1'b0, BSR_LEN_DEFAULT, d, rq);
      chk(rq, {16'h0, pin_level_in});
      chk(bsr_update_out, d[15:0]);
    end else begin
      tester.scan(1'b0, 8, d, rq);
      chk(rq, {24'h0, d[6:0], 1'b0});
    end
  endtask : load
  task conclude();
    $display("comparisons=%0d fail_count=%0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : conclude
  // unconfigured with restart held low, restart release, then configured, last with the always-enable option
  initial begin
    repeat (10) @(posedge sys_clk_in);
    #1 rst_b_in = 1'b1;
    repeat (4) @(posedge sys_clk_in);
    #1 usercode_in = rnd();
    pin_level_in = BSR_LEN_DEFAULT'(rnd());
    keeper_en_in = BSR_LEN_DEFAULT'(rnd());
    config_restart_n_in = 1'b0;
    tester.scan(1'b0, ID_W, rnd(), rq);
    chk(rq, ID_DEFAULT);
    foreach (codes[i]) load(codes[i]);
    load(IR_CONFIG_IO);
    @(posedge sys_clk_in);
    #1 config_restart_n_in = 1'b1;
    m_abort = 0;
    repeat (8) @(posedge sys_clk_in);
    #1 chk(config_abort_out, 1'b0);
    config_done_in = 1'b1;
    keeper_en_in = BSR_LEN_DEFAULT'(rnd());
    foreach (codes[i]) load(codes[i]);
    @(posedge sys_clk_in);
    #1 always_en_inbuf_in = 1'b1;
    load(IR_IDCODE);
    chk(pulses, m_pulses);
    conclude();
  end
endmodule : testbench
